// ### rtl/gsw_pkg.sv
// Package: constants for the strap, pin and wake logic
package gsw_pkg;
  localparam int GSW_PINS = 8;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] GSW_REG_OE = 8'h00;
  localparam logic [7:0] GSW_REG_OUT = 8'h04;
  localparam logic [7:0] GSW_REG_IN = 8'h08;
  localparam logic [7:0] GSW_REG_STRAP = 8'h0c;
  localparam logic [7:0] GSW_REG_STATUS = 8'h10;
  localparam logic [7:0] GSW_REG_MASK = 8'h14;
  localparam logic [7:0] GSW_REG_WAKECTL = 8'h18;
  // Strap field positions on the pins
  localparam int GSW_ORG_BIT = 7;
  localparam int GSW_RXT_HI = 6;
  localparam int GSW_RXT_LO = 5;
  localparam int GSW_TXT_HI = 4;
  localparam int GSW_TXT_LO = 3;
  localparam int GSW_DEQ_HI = 2;
  localparam int GSW_DEQ_LO = 0;
  // Reset values of captured straps (unstrapped defaults) and of the output enables
  localparam logic GSW_ORG_RST = 1'b0;
  localparam logic [1:0] GSW_RXT_RST = 2'h0;
  localparam logic [1:0] GSW_TXT_RST = 2'h0;
  localparam logic [2:0] GSW_DEQ_RST = 3'h4;
  localparam logic [7:0] GSW_OE_RST = 8'h00;
  // Status bits
  localparam int GSW_ST_WAKE = 0;
  localparam int GSW_ST_RING = 1;
  localparam int GSW_ST_W = 2;
endpackage

// ### rtl/gsw_strap_cap.sv
// Strap capture: samples the pins once after system reset release
`timescale 1ns/1ps
`default_nettype none
module gsw_strap_cap
  import gsw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic system_reset_n,
  input wire logic [7:0] pin_in,
  output logic strap_done,
  output logic eeprom_org_strap,
  output logic [1:0] rx_termination_code,
  output logic [1:0] tx_termination_code,
  output logic [2:0] driver_equalization_code
);
  logic done;
  logic next_done;
  logic org;
  logic next_org;
  logic [1:0] rxt;
  logic [1:0] next_rxt;
  logic [1:0] txt;
  logic [1:0] next_txt;
  logic [2:0] deq;
  logic [2:0] next_deq;

  always_comb
  begin
    next_done = done;
    next_org = org;
    next_rxt = rxt;
    next_txt = txt;
    next_deq = deq;
    if (!system_reset_n)
    begin
      next_done = 1'b0;
    end
    else if (!done)
    begin
      // Clocked capture at release, never an async load from a pin
      next_done = 1'b1; // R7
      next_org = pin_in[GSW_ORG_BIT]; // R2
      next_rxt = pin_in[GSW_RXT_HI:GSW_RXT_LO]; // R3
      next_txt = pin_in[GSW_TXT_HI:GSW_TXT_LO]; // R4
      next_deq = pin_in[GSW_DEQ_HI:GSW_DEQ_LO]; // R5
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      done <= 1'b0;
      org <= GSW_ORG_RST;
      rxt <= GSW_RXT_RST;
      txt <= GSW_TXT_RST;
      deq <= GSW_DEQ_RST;
    end
    else
    begin
      done <= next_done;
      org <= next_org;
      rxt <= next_rxt;
      txt <= next_txt;
      deq <= next_deq;
    end
  end

  assign strap_done = done;
  assign eeprom_org_strap = org;
  assign rx_termination_code = rxt;
  assign tx_termination_code = txt;
  assign driver_equalization_code = deq;

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (done && system_reset_n) |=> $stable(deq) && $stable(org))
    else $error("strap value changed after capture");
  strap_take_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (!done && system_reset_n) |=> done && rxt == $past(pin_in[6:5]))
    else $error("receive termination code not captured");
endmodule
`default_nettype wire

// ### rtl/gsw_top.sv
// Top: general-purpose pins, strap capture, wake output and registers
//
// Operation
// R1: Eight pins each act as input-only or driven according to a writable output-enable bit.
// R2: Pin 7 sampled at initialization selects 16-bit configuration words when high, else 8-bit.
// R3: Pins 6 and 5 sampled at initialization give the receive termination code, default 00.
// R4: Pins 4 and 3 sampled at initialization give the transmit termination code, default 00.
// R5: Pins 2 to 0 sampled at initialization give equalization bits 3 to 1, default 100.
// R6: The active-low wake output asserts when channel 0 ring indication arrives in L2.
// R7: Straps latch at system reset release and hold; then the pins follow the registers.
`timescale 1ns/1ps
`default_nettype none
module gsw_top
  import gsw_pkg::*;
#(
  parameter int PINS = GSW_PINS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic system_reset_n,
  input wire logic [PINS-1:0] gpio_in,
  output logic [PINS-1:0] gpio_out,
  output logic [PINS-1:0] gpio_oe_n,
  input wire logic ring_ch0,
  input wire logic link_in_l2,
  output logic wake_n,
  output logic eeprom_org_strap,
  output logic eeprom_word16,
  output logic [1:0] rx_termination_code,
  output logic [1:0] tx_termination_code,
  output logic [2:0] driver_equalization_code,
  output logic strap_done,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  logic [PINS-1:0] oe;
  logic [PINS-1:0] next_oe;
  logic [PINS-1:0] dout;
  logic [PINS-1:0] next_dout;
  logic [GSW_ST_W-1:0] status;
  logic [GSW_ST_W-1:0] next_status;
  logic [GSW_ST_W-1:0] mask;
  logic [GSW_ST_W-1:0] next_mask;
  logic wake_en;
  logic next_wake_en;
  logic wake;
  logic next_wake;
  logic ring_q;
  logic next_ring_q;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ring_rise;
  logic wake_set;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  gsw_strap_cap u_cap (
    .clk_sys(clk_sys),
    .rst(rst),
    .system_reset_n(system_reset_n),
    .pin_in(gpio_in[7:0]),
    .strap_done(strap_done),
    .eeprom_org_strap(eeprom_org_strap),
    .rx_termination_code(rx_termination_code),
    .tx_termination_code(tx_termination_code),
    .driver_equalization_code(driver_equalization_code)
  );

  assign eeprom_word16 = eeprom_org_strap; // R2
  assign ring_rise = ring_ch0 && !ring_q;
  assign wake_set = ring_rise && link_in_l2 && wake_en; // R6

  always_comb
  begin
    next_oe = oe;
    next_dout = dout;
    next_mask = mask;
    next_wake_en = wake_en;
    next_ring_q = ring_ch0;
    next_wake = wake;
    next_status = status;
    next_rdata = 32'h0;
    if (reg_wr && hit(reg_addr, GSW_REG_OE))
      next_oe = reg_wdata[PINS-1:0]; // R1
    if (reg_wr && hit(reg_addr, GSW_REG_OUT))
      next_dout = reg_wdata[PINS-1:0];
    if (reg_wr && hit(reg_addr, GSW_REG_MASK))
      next_mask = reg_wdata[GSW_ST_W-1:0];
    if (reg_wr && hit(reg_addr, GSW_REG_WAKECTL))
      next_wake_en = reg_wdata[0];
    // Write-one-to-clear; a new event in the same cycle wins
    if (reg_wr && hit(reg_addr, GSW_REG_STATUS))
      next_status = status & ~reg_wdata[GSW_ST_W-1:0];
    if (wake_set)
      next_status[GSW_ST_WAKE] = 1'b1;
    if (ring_rise)
      next_status[GSW_ST_RING] = 1'b1;
    // Wake stays asserted until the link leaves L2
    if (wake_set)
      next_wake = 1'b1; // R6
    else if (!link_in_l2)
      next_wake = 1'b0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        GSW_REG_OE: next_rdata = {{(32-PINS){1'b0}}, oe};
        GSW_REG_OUT: next_rdata = {{(32-PINS){1'b0}}, dout};
        GSW_REG_IN: next_rdata = {{(32-PINS){1'b0}}, gpio_in};
        GSW_REG_STRAP: next_rdata = {24'h0, eeprom_org_strap, rx_termination_code,
          tx_termination_code, driver_equalization_code};
        GSW_REG_STATUS: next_rdata = {{(32-GSW_ST_W){1'b0}}, status};
        GSW_REG_MASK: next_rdata = {{(32-GSW_ST_W){1'b0}}, mask};
        GSW_REG_WAKECTL: next_rdata = {31'h0, wake_en};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      oe <= GSW_OE_RST;
      dout <= '0;
      mask <= '0;
      wake_en <= 1'b1;
      ring_q <= 1'b0;
      wake <= 1'b0;
      status <= '0;
      rdata <= 32'h0;
    end
    else
    begin
      oe <= next_oe;
      dout <= next_dout;
      mask <= next_mask;
      wake_en <= next_wake_en;
      ring_q <= next_ring_q;
      wake <= next_wake;
      status <= next_status;
      rdata <= next_rdata;
    end
  end

  // Pins stay undriven until straps are taken so the board straps are read cleanly
  assign gpio_oe_n = ~(oe & {PINS{strap_done}}); // R1 R7
  assign gpio_out = dout;
  assign wake_n = ~wake; // R6
  assign irq = |(status & mask);
  assign reg_rdata = rdata;

  // Enable gates the pin and the wake status bit; the ring bit records every rising edge
  wake_cause_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (ring_ch0 && !ring_q && link_in_l2 && wake_en) |=> !wake_n)
    else $error("wake not asserted on ring in L2");
  wake_only_l2_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    $fell(wake_n) |-> $past(link_in_l2))
    else $error("wake asserted outside L2");
  wake_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (!wake_n && link_in_l2) |=> !wake_n)
    else $error("wake released while in L2");
  wake_end_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    !link_in_l2 |=> wake_n)
    else $error("wake held after L2 exit");
  wake_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (ring_ch0 && !ring_q && !wake_en && wake_n) |=> wake_n)
    else $error("wake asserted while disabled");
  ring_set_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (ring_ch0 && !ring_q) |=> status[GSW_ST_RING])
    else $error("ring edge not recorded");
  irq_raise_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ring_ch0 && !ring_q && mask[GSW_ST_RING] && !reg_wr) |=> irq)
    else $error("interrupt not raised on ring edge");

  // Pins and register map
  oe_write_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (reg_wr && reg_addr == GSW_REG_OE && strap_done && system_reset_n)
    |=> gpio_oe_n == ~$past(reg_wdata[PINS-1:0]))
    else $error("output enable not applied");
  out_write_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (reg_wr && reg_addr == GSW_REG_OUT) |=> gpio_out == $past(reg_wdata[PINS-1:0]))
    else $error("output data not applied");
  in_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (reg_rd && reg_addr == GSW_REG_IN) |=> reg_rdata[PINS-1:0] == $past(gpio_in))
    else $error("pin levels not read back");
  no_drive_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    !strap_done |-> &gpio_oe_n)
    else $error("pin driven before strap capture");
  oe_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    !system_reset_n |=> &gpio_oe_n)
    else $error("pin driven during system reset");
  strap_ro_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (reg_wr && reg_addr == GSW_REG_STRAP && strap_done && system_reset_n)
    |=> $stable(eeprom_org_strap) && $stable(rx_termination_code))
    else $error("strap value written by software");
  rdata_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outlived its cycle");

  // Strap capture as seen at the top
  org_capture_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (!strap_done && system_reset_n) |=> eeprom_word16 == $past(gpio_in[GSW_ORG_BIT]))
    else $error("word organization not captured");
  tx_code_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (!strap_done && system_reset_n) |=> tx_termination_code == $past(gpio_in[4:3]))
    else $error("transmit termination code not captured");
  deq_code_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (!strap_done && system_reset_n) ##1 1'b1 [*2]
    |-> driver_equalization_code == $past(gpio_in[2:0], 2))
    else $error("equalization code not captured");
  strap_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (reg_rd && reg_addr == GSW_REG_STRAP) |=> reg_rdata[2:0] == $past(driver_equalization_code))
    else $error("equalization code not read back");
endmodule
`default_nettype wire

// ### verification/gsw_board.sv
// Board model: strap resistors and weak pin pulls seen by the pins
`timescale 1ns/1ps
`default_nettype none
module gsw_board
  import gsw_pkg::*;
(
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe_n,
  input wire logic [7:0] strap_val,
  input wire logic strap_fit,
  output logic [7:0] gpio_in
);
  // Pin 2 pulls up, the others pull down, so unfitted straps give 0, 00, 00, 100
  localparam logic [7:0] PULL = 8'h04;
  always_comb
  begin
    for (int i = 0; i < GSW_PINS; i++)
    begin
      gpio_in[i] = !gpio_oe_n[i] ? gpio_out[i] : (strap_fit ? strap_val[i] : PULL[i]);
    end
  end
endmodule
`default_nettype wire

// ### verification/gpio_strap_and_wake_logic_test.sv
// Testbench: straps, pins, registers and wake output of the pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) chk(nm, 32'(ex), 32'(gt))
module gpio_strap_and_wake_logic_test
  import gsw_pkg::*;
;
  logic clk_sys, rst, system_reset_n, ring_ch0, link_in_l2, reg_wr, reg_rd, strap_fit, org, w16;
  logic strap_done, wake_n, irq;
  logic [7:0] reg_addr, strap_val, gpio_in, gpio_out, gpio_oe_n;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] rxc, txc;
  logic [2:0] deqc;
  int miscompares = 0;
  int n_compared = 0;
  gsw_top DUT (.clk_sys(clk_sys), .rst(rst), .system_reset_n(system_reset_n),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ring_ch0(ring_ch0),
    .link_in_l2(link_in_l2), .wake_n(wake_n), .eeprom_org_strap(org), .eeprom_word16(w16),
    .rx_termination_code(rxc), .tx_termination_code(txc), .driver_equalization_code(deqc),
    .strap_done(strap_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  gsw_board board (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .strap_val(strap_val),
    .strap_fit(strap_fit), .gpio_in(gpio_in));
  always #50 clk_sys = ~clk_sys;
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    n_compared++;
    if (gt !== ex)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata);
  endtask
  task automatic capture(input logic [7:0] v, input logic f);
    int n = 0;
    @(posedge clk_sys);
    system_reset_n <= 1'b0;
    strap_val <= v;
    strap_fit <= f;
    repeat (3) @(posedge clk_sys);
    system_reset_n <= 1'b1;
    while (strap_done !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (strap_done !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic t_default();
    capture(8'h00, 1'b0);
    `CHK("org", 1'b0, org);
    `CHK("word16", 1'b0, w16);
    `CHK("rx", 2'h0, rxc);
    `CHK("tx", 2'h0, txc);
    `CHK("deq", 3'h4, deqc);
    `CHK("done", 1'b1, strap_done);
    rd(GSW_REG_STRAP, 32'h04);
  endtask
  task automatic t_strap();
    capture(8'hb5, 1'b1);
    strap_val <= 8'h4a;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("word16", 1'b1, w16);
    `CHK("rx", 2'h1, rxc);
    `CHK("tx", 2'h2, txc);
    `CHK("deq", 3'h5, deqc);
    wr(GSW_REG_STRAP, 32'h00);
    rd(GSW_REG_STRAP, 32'hb5);
  endtask
  task automatic t_pins();
    wr(GSW_REG_OE, 32'h0f);
    wr(GSW_REG_OUT, 32'ha5);
    #1;
    `CHK("oe_n", 8'hf0, gpio_oe_n);
    `CHK("out", 8'ha5, gpio_out);
    repeat (3) @(posedge clk_sys);
    rd(GSW_REG_IN, 32'h45);
    rd(8'h1c, 32'h00);
  endtask
  task automatic t_wake();
    wr(GSW_REG_MASK, 32'h03);
    link_in_l2 <= 1'b1;
    @(posedge clk_sys);
    ring_ch0 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("wake_n", 1'b0, wake_n);
    `CHK("irq", 1'b1, irq);
    link_in_l2 <= 1'b0;
    ring_ch0 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("wake_n", 1'b1, wake_n);
    rd(GSW_REG_STATUS, 32'h03);
    wr(GSW_REG_STATUS, 32'h03);
    rd(GSW_REG_STATUS, 32'h00);
    wr(GSW_REG_MASK, 32'h01);
    ring_ch0 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("wake_n", 1'b1, wake_n);
    `CHK("irq", 1'b0, irq);
    rd(GSW_REG_STATUS, 32'h02);
    // Clear and a new ring edge in one cycle: the edge must win
    ring_ch0 <= 1'b0;
    @(posedge clk_sys);
    reg_addr <= GSW_REG_STATUS;
    reg_wdata <= 32'h03;
    reg_wr <= 1'b1;
    ring_ch0 <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    rd(GSW_REG_STATUS, 32'h02);
    rd(GSW_REG_WAKECTL, 32'h01);
    wr(GSW_REG_WAKECTL, 32'h00);
    wr(GSW_REG_STATUS, 32'h03);
    rd(GSW_REG_WAKECTL, 32'h00);
    link_in_l2 <= 1'b1;
    ring_ch0 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    ring_ch0 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("wake_n", 1'b1, wake_n);
    rd(GSW_REG_STATUS, 32'h02);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    system_reset_n = 1'b0;
    ring_ch0 = 1'b0;
    link_in_l2 = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    strap_val = 8'h00;
    strap_fit = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_default();
    t_strap();
    t_pins();
    t_wake();
    complete_run();
  end
endmodule
`default_nettype wire
